// ---- sacap_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the slope converter control.
`ifndef SACAP_DEFINES_SVH
`define SACAP_DEFINES_SVH
// Printed offsets are not all multiples of four, so they are indices; byte address is index * 4.
`define SACAP_IDX_TMR_LO      8'h0e
`define SACAP_IDX_TMR_HI      8'h0f
`define SACAP_IDX_CAP_LO      8'h15
`define SACAP_IDX_CAP_HI      8'h16
`define SACAP_IDX_CTRL0       8'h1f
`define SACAP_IDX_CTRL1       8'h20
`define SACAP_IDX_FLAGS       8'h21
`define SACAP_IDX_ENABLES     8'h22
`define SACAP_IDX_INTCTL      8'h23
`define SACAP_IDX_PWR         8'h24
// Field positions.
`define SACAP_CTRL0_RST_BIT   1
`define SACAP_FLAG_CAP_BIT    1
`define SACAP_FLAG_OVF_BIT    0
`define SACAP_INT_GIE_BIT     7
`define SACAP_INT_PIE_BIT     6
`define SACAP_PWR_REF_BIT     5
`define SACAP_PWR_CONV_BIT    0
// Reset values.
`define SACAP_CTRL0_RESET     8'h02
`define SACAP_CTRL1_RESET     8'h00
`define SACAP_PWR_RESET       8'h21
`define SACAP_TMR_RESET       16'h0000
// Least discharge time, held by software.
`define SACAP_DISCHARGE_NS    200000
`define SACAP_CLK_PERIOD_NS   4
`define SACAP_DISCHARGE_CYC   ((`SACAP_DISCHARGE_NS + `SACAP_CLK_PERIOD_NS - 1) / `SACAP_CLK_PERIOD_NS)
`endif

// ---- sacap_pkg.sv ----
// Types shared by the slope converter control.
package sacap_pkg;
  // Channel select codes of the analog mux.
  typedef enum logic [3:0] {
    SACAP_CH_EXT0 = 4'h0, SACAP_CH_EXT1 = 4'h1, SACAP_CH_EXT2 = 4'h2, SACAP_CH_EXT3 = 4'h3,
    SACAP_CH_BANDGAP = 4'h4, SACAP_CH_SLOPE_REF_HIGH = 4'h5, SACAP_CH_SLOPE_REF_LOW = 4'h6,
    SACAP_CH_TEMP = 4'h7, SACAP_CH_PREF_A = 4'h8, SACAP_CH_PREF_B = 4'h9,
    SACAP_CH_EXT4 = 4'ha, SACAP_CH_EXT5 = 4'hb, SACAP_CH_EXT6 = 4'hc, SACAP_CH_EXT7 = 4'hd,
    SACAP_CH_RSVD0 = 4'he, SACAP_CH_RSVD1 = 4'hf
  } sacap_chan_type;
  // Timer write sequence state.
  typedef enum logic [2:0] {
    SACAP_SEQ_IDLE  = 3'b001,
    SACAP_SEQ_HIGH  = 3'b010,
    SACAP_SEQ_BLOCK = 3'b100
  } sacap_seq_type;
endpackage : sacap_pkg

// ---- sacap_sync.sv ----
// Three-stage comparator synchroniser with agreement filter and falling-edge pulse.
`timescale 1ns/100ps
`default_nettype none
module sacap_sync (
  input  wire logic clk_i,      // Oscillator clock.
  input  wire logic reset_n_i,  // Asynchronous reset, active low.
  input  wire logic async_i,    // Comparator output from the analog side.
  output logic      level_o,    // Filtered comparator level.
  output logic      fall_o      // One-cycle pulse on a high-to-low change.
);
  logic s1_q;  // First stage; read only by the second.
  logic s2_q;  // Second stage.
  logic s3_q;  // Third stage.
  // Chain and filter; a change counts once stages two and three agree.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_o <= 1'b1;
      fall_o  <= 1'b0;
    end else begin
      s1_q   <= async_i;  // RL21
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      fall_o <= 1'b0;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
        fall_o  <= level_o & ~s3_q;  // RL21
      end
    end
  end
endmodule : sacap_sync
`default_nettype wire

// ---- sacap_top.sv ----
// Slope converter timer, capture, flags and AXI4-Lite register slave.
// Contract
// RL1: 16-bit timer counts every clock when running.
// RL2: Power-up reset loads timer with zero.
// RL3: Software initialises timer before each conversion.
// RL4: Ramp reset stops timer, sources, discharges.
// RL5: Clearing ramp reset starts count and charge.
// RL6: Software holds ramp reset 200 us.
// RL7: Comparator fall captures timer, sets capture flag.
// RL8: Timer keeps counting after capture.
// RL9: At most one capture per conversion cycle.
// RL10: Capture request needs flag and three enables.
// RL11: Timer wrap sets overflow flag, keeps counting.
// RL12: Overflow request needs flag and three enables.
// RL13: Software clears flags; hardware never clears them.
// RL14: Timer and capture bytes readable and writable.
// RL15: High byte first; low first leaves timer stopped.
// RL16: Software avoids timer access during conversion.
// RL17: Four-bit channel select with fixed codes.
// RL18: Four-bit current code, zero means off.
// RL19: Software powers up, sets current, then resets.
// RL20: Full span 65536 counts on either oscillator.
// RL21: Comparator synchronised before edge detect.
`timescale 1ns/100ps
`default_nettype none
`include "sacap_defines.svh"
module sacap_top (
  input  wire logic        clk_i,           // Oscillator clock, 250 MHz.
  input  wire logic        reset_n_i,       // Power-up reset, asynchronous, active low.
  input  wire logic [31:0] s_axi_awaddr,    // Write address.
  input  wire logic        s_axi_awvalid,   // Write address valid.
  output logic             s_axi_awready,   // Write address ready.
  input  wire logic [31:0] s_axi_wdata,     // Write data.
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes.
  input  wire logic        s_axi_wvalid,    // Write data valid.
  output logic             s_axi_wready,    // Write data ready.
  output logic [1:0]       s_axi_bresp,     // Write response.
  output logic             s_axi_bvalid,    // Write response valid.
  input  wire logic        s_axi_bready,    // Write response ready.
  input  wire logic [31:0] s_axi_araddr,    // Read address.
  input  wire logic        s_axi_arvalid,   // Read address valid.
  output logic             s_axi_arready,   // Read address ready.
  output logic [31:0]      s_axi_rdata,     // Read data.
  output logic [1:0]       s_axi_rresp,     // Read response.
  output logic             s_axi_rvalid,    // Read data valid.
  input  wire logic        s_axi_rready,    // Read data ready.
  input  wire logic        comparator_i,    // Comparator output, asynchronous.
  output logic [3:0]       channel_sel_o,   // Analog mux channel code.
  output logic [3:0]       current_code_o,  // Ramp current-source code.
  output logic             discharge_o,     // Ramp capacitor discharge, active high.
  output logic             ref_power_dn_o,  // Reference power-down.
  output logic             conv_power_dn_o, // Converter power-down.
  output logic             irq_o            // Converter interrupt request, active high.
);
  localparam logic [1:0] RESP_OKAY   = 2'b00;  // Normal answer.
  localparam logic [1:0] RESP_SLVERR = 2'b10;  // Answer to an unmapped address.

  logic [15:0] timer_q;        // Conversion timer.
  logic [15:0] capture_q;      // Capture register.
  logic [7:0]  ctrl0_q;        // Channel select and ramp reset control.
  logic [7:0]  ctrl1_q;        // Current code and port configuration bits.
  logic        cap_flag_q;     // Capture flag.
  logic        ovf_flag_q;     // Overflow flag.
  logic        cap_ie_q;       // Capture interrupt enable.
  logic        ovf_ie_q;       // Overflow interrupt enable.
  logic        gie_q;          // Global interrupt enable.
  logic        pie_q;          // Peripheral interrupt enable.
  logic [7:0]  pwr_q;          // Power control register.
  logic        armed_q;        // A capture is still allowed in this cycle.
  sacap_pkg::sacap_seq_type seq_q;  // Timer write order tracker.
  logic        aw_held_q;      // Write address taken, waiting for data.
  logic        w_held_q;       // Write data taken, waiting for address.
  logic [7:0]  aw_idx_q;       // Held write register index.
  logic [7:0]  wdata_q;        // Held write byte.
  logic        wstrb_q;        // Held low-lane strobe.
  logic        comp_level;     // Filtered comparator level.
  logic        comp_fall;      // Comparator falling-edge pulse.
  logic        wr_go;          // Write performed this cycle.
  logic        running;        // Timer advances this cycle.
  logic        cap_event;      // Capture accepted this cycle.
  logic        wr_hit;         // Write index maps to a register.

  // Turns a byte address into a register index; bits [1:0] select no lane here.
  function automatic logic [7:0] addr_to_idx(input logic [31:0] a);
    addr_to_idx = a[9:2];
  endfunction : addr_to_idx

  // True when an index names one of the registers.
  function automatic logic idx_mapped(input logic [7:0] i);
    case (i)
      `SACAP_IDX_TMR_LO, `SACAP_IDX_TMR_HI, `SACAP_IDX_CAP_LO, `SACAP_IDX_CAP_HI,
      `SACAP_IDX_CTRL0, `SACAP_IDX_CTRL1, `SACAP_IDX_FLAGS, `SACAP_IDX_ENABLES,
      `SACAP_IDX_INTCTL, `SACAP_IDX_PWR: idx_mapped = 1'b1;
      default:                           idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  sacap_sync u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (comparator_i),
    .level_o   (comp_level),
    .fall_o    (comp_fall)
  );

  // Writes land once both halves are held and no response is pending; bytes travel in lane zero only.
  assign wr_go     = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_hit    = idx_mapped(aw_idx_q);
  // A low-first write parks the timer until the next high byte write.
  assign running   = ~ctrl0_q[`SACAP_CTRL0_RST_BIT]
                   & (seq_q != sacap_pkg::SACAP_SEQ_BLOCK);  // RL1 RL4 RL5 RL15
  assign cap_event = comp_fall & armed_q & ~ctrl0_q[`SACAP_CTRL0_RST_BIT];  // RL9

  // Write address and data are taken independently, in either order.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb_q   <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= addr_to_idx(s_axi_awaddr);
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb_q  <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Ready stays high while the matching half is not yet held.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~(aw_held_q | (s_axi_awvalid & s_axi_awready)) | wr_go;
      s_axi_wready  <= ~(w_held_q | (s_axi_wvalid & s_axi_wready)) | wr_go;
    end
  end

  // Write response one cycle after the write lands.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Conversion timer: software bytes win over counting in their cycle.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_q <= `SACAP_TMR_RESET;  // RL2
    end else if (wr_go && wstrb_q && aw_idx_q == `SACAP_IDX_TMR_HI) begin
      timer_q[15:8] <= wdata_q;  // RL14
    end else if (wr_go && wstrb_q && aw_idx_q == `SACAP_IDX_TMR_LO) begin
      timer_q[7:0] <= wdata_q;  // RL14
    end else if (running) begin
      timer_q <= timer_q + 16'h0001;  // RL1 RL8 RL20
    end
  end

  // Write order tracker: high then low is fine, low alone blocks the timer.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_q <= sacap_pkg::SACAP_SEQ_IDLE;
    end else if (wr_go && wstrb_q) begin
      case (aw_idx_q)
        `SACAP_IDX_TMR_HI: seq_q <= sacap_pkg::SACAP_SEQ_HIGH;
        `SACAP_IDX_TMR_LO: begin
          seq_q <= (seq_q == sacap_pkg::SACAP_SEQ_HIGH) ? sacap_pkg::SACAP_SEQ_IDLE
                                                      : sacap_pkg::SACAP_SEQ_BLOCK;  // RL15
        end
        default: seq_q <= seq_q;
      endcase
    end
  end

  // Capture register: a comparator fall copies the live count.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      capture_q <= 16'h0000;
    end else if (cap_event) begin
      capture_q <= timer_q;  // RL7
    end else if (wr_go && wstrb_q && aw_idx_q == `SACAP_IDX_CAP_LO) begin
      capture_q[7:0] <= wdata_q;  // RL14
    end else if (wr_go && wstrb_q && aw_idx_q == `SACAP_IDX_CAP_HI) begin
      capture_q[15:8] <= wdata_q;  // RL14
    end
  end

  // One capture per cycle; the arm is restored while ramp reset is held.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_q <= 1'b1;
    end else if (ctrl0_q[`SACAP_CTRL0_RST_BIT]) begin
      armed_q <= 1'b1;
    end else if (cap_event) begin
      armed_q <= 1'b0;  // RL9
    end
  end

  // Flags: hardware only sets; a set wins over a software clear in the same cycle.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cap_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
    end else begin
      if (cap_event) begin
        cap_flag_q <= 1'b1;  // RL7
      end else if (wr_go && wstrb_q && aw_idx_q == `SACAP_IDX_FLAGS) begin
        cap_flag_q <= wdata_q[`SACAP_FLAG_CAP_BIT];  // RL13
      end
      if (running && timer_q == 16'hffff) begin
        ovf_flag_q <= 1'b1;  // RL11
      end else if (wr_go && wstrb_q && aw_idx_q == `SACAP_IDX_FLAGS) begin
        ovf_flag_q <= wdata_q[`SACAP_FLAG_OVF_BIT];  // RL13
      end
    end
  end

  // Control, enable and power registers written by software.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl0_q  <= `SACAP_CTRL0_RESET;
      ctrl1_q  <= `SACAP_CTRL1_RESET;
      cap_ie_q <= 1'b0;
      ovf_ie_q <= 1'b0;
      gie_q    <= 1'b0;
      pie_q    <= 1'b0;
      pwr_q    <= `SACAP_PWR_RESET;
    end else if (wr_go && wstrb_q) begin
      case (aw_idx_q)
        `SACAP_IDX_CTRL0: ctrl0_q <= wdata_q & 8'hf7;  // RL17
        `SACAP_IDX_CTRL1: ctrl1_q <= wdata_q;  // RL18
        `SACAP_IDX_ENABLES: begin
          cap_ie_q <= wdata_q[`SACAP_FLAG_CAP_BIT];
          ovf_ie_q <= wdata_q[`SACAP_FLAG_OVF_BIT];
        end
        `SACAP_IDX_INTCTL: begin
          gie_q <= wdata_q[`SACAP_INT_GIE_BIT];
          pie_q <= wdata_q[`SACAP_INT_PIE_BIT];
        end
        `SACAP_IDX_PWR: pwr_q <= wdata_q;
        default: pwr_q <= pwr_q;
      endcase
    end
  end

  // Analog-side outputs; ramp reset forces sources off and discharges.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      channel_sel_o   <= 4'h0;
      current_code_o  <= 4'h0;
      discharge_o     <= 1'b1;
      ref_power_dn_o  <= 1'b1;
      conv_power_dn_o <= 1'b1;
    end else begin
      channel_sel_o   <= ctrl0_q[7:4];  // RL17
      current_code_o  <= ctrl0_q[`SACAP_CTRL0_RST_BIT] ? 4'h0 : ctrl1_q[7:4];  // RL4 RL5 RL18
      discharge_o     <= ctrl0_q[`SACAP_CTRL0_RST_BIT];  // RL4
      ref_power_dn_o  <= pwr_q[`SACAP_PWR_REF_BIT];
      conv_power_dn_o <= pwr_q[`SACAP_PWR_CONV_BIT];
    end
  end

  // Interrupt request needs the flag, its enable and both global enables.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= gie_q & pie_q & ((cap_flag_q & cap_ie_q)       // RL10
                              | (ovf_flag_q & ovf_ie_q));     // RL12
    end
  end

  // Read channel: one request at a time, data one cycle after the address.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= idx_mapped(addr_to_idx(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
      case (addr_to_idx(s_axi_araddr))
        `SACAP_IDX_TMR_LO:  s_axi_rdata <= {24'h000000, timer_q[7:0]};  // RL14
        `SACAP_IDX_TMR_HI:  s_axi_rdata <= {24'h000000, timer_q[15:8]};
        `SACAP_IDX_CAP_LO:  s_axi_rdata <= {24'h000000, capture_q[7:0]};
        `SACAP_IDX_CAP_HI:  s_axi_rdata <= {24'h000000, capture_q[15:8]};
        `SACAP_IDX_CTRL0:   s_axi_rdata <= {24'h000000, ctrl0_q};
        `SACAP_IDX_CTRL1:   s_axi_rdata <= {24'h000000, ctrl1_q};
        `SACAP_IDX_FLAGS:   s_axi_rdata <= {30'h00000000, cap_flag_q, ovf_flag_q};
        `SACAP_IDX_ENABLES: s_axi_rdata <= {30'h00000000, cap_ie_q, ovf_ie_q};
        `SACAP_IDX_INTCTL:  s_axi_rdata <= {24'h000000, gie_q, pie_q, 6'h00};
        `SACAP_IDX_PWR:     s_axi_rdata <= {24'h000000, pwr_q};
        default:            s_axi_rdata <= {31'h00000000, comp_level};
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : sacap_top
`default_nettype wire

// ---- sacap_top_assertions.sv ----
// Port-level checker for the slope converter control, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module sacap_chk (
  input wire logic        clk_i,          // Oscillator clock.
  input wire logic        reset_n_i,      // Reset, active low.
  input wire logic        s_axi_awvalid,  // Write address valid.
  input wire logic        s_axi_awready,  // Write address ready.
  input wire logic        s_axi_wvalid,   // Write data valid.
  input wire logic        s_axi_wready,   // Write data ready.
  input wire logic [1:0]  s_axi_bresp,    // Write response.
  input wire logic        s_axi_bvalid,   // Write response valid.
  input wire logic        s_axi_bready,   // Write response ready.
  input wire logic        s_axi_arvalid,  // Read address valid.
  input wire logic        s_axi_arready,  // Read address ready.
  input wire logic [31:0] s_axi_rdata,    // Read data.
  input wire logic        s_axi_rvalid,   // Read data valid.
  input wire logic        s_axi_rready,   // Read data ready.
  input wire logic        comparator_i,   // Comparator level.
  input wire logic [3:0]  channel_sel_o,  // Channel code.
  input wire logic [3:0]  current_code_o, // Current code.
  input wire logic        discharge_o,    // Discharge output.
  input wire logic        irq_o           // Interrupt request.
);
  // One clock domain, so clocking and reset gating are declared once.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Sources must be off whenever the capacitor is being discharged.
  AST_CUR_OFF: assert property (discharge_o |-> current_code_o == 4'h0)
    else $error("current code not zero during discharge");
  // A taken read address is answered on the next cycle.
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  // Registers are bytes, so the upper read lanes stay zero.
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted while one pending");
  AST_WR_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  // Analog controls only move as the result of a register write a few cycles earlier.
  AST_CH_CAUSE: assert property ($changed(channel_sel_o) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("channel changed without a write");
  AST_DIS_CAUSE: assert property ($changed(discharge_o) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("discharge changed without a write");
  // Main scenarios reached.
  COV_IRQ: cover property ($rose(irq_o));
  COV_TRIP: cover property ($fell(comparator_i) && !discharge_o);
  COV_START: cover property ($fell(discharge_o));
endmodule : sacap_chk
bind sacap_top sacap_chk u_chk (.clk_i, .reset_n_i, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .comparator_i, .channel_sel_o,
  .current_code_o, .discharge_o, .irq_o);
`default_nettype wire

// ---- sacap_ramp_model.sv ----
// Behavioural ramp capacitor, current source and comparator on the analog side.
`timescale 1ns/100ps
`default_nettype none
`include "sacap_defines.svh"
module sacap_ramp_model #(
  parameter int HOLD_CYC = `SACAP_DISCHARGE_CYC // Cycles for a full discharge.
) (
  input  wire logic        clk_i,       // Oscillator clock.
  input  wire logic        discharge_i, // Discharge control.
  input  wire logic [3:0]  current_i,   // Current code, zero is off.
  input  wire logic [31:0] trip_i,      // Input level in ramp steps.
  output logic             cmp_o        // High while the ramp is at or below the input.
);
  int unsigned ramp = 0, held = 0; // Ramp level in smallest-current steps; cycles discharged.
  // A short discharge leaves charge behind, as a real capacitor would.
  always @(posedge clk_i) begin
    if (discharge_i) begin
      held <= held + 1;
      if (held + 1 >= HOLD_CYC) ramp <= 0;
    end else begin
      held <= 0;
      ramp <= ramp + current_i;
    end
  end
  // Comparator switches off the clock edge, like an asynchronous pin.
  assign #1.3 cmp_o = (ramp <= trip_i);
endmodule : sacap_ramp_model
`default_nettype wire

// ---- test_slope_adc_timer_capture.sv ----
// Self-checking bench for the slope converter control.
`timescale 1ns/100ps
`default_nettype none
`include "sacap_defines.svh"
module test_slope_adc_timer_capture;
  localparam int HOLD = 64;     // Scaled discharge time of the model.
  logic        clk_i = 1'b0, reset_n_i = 1'b0; // Clock and reset.
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, trip = '1, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, channel_sel_o, current_code_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, comparator_i, discharge_o, ref_power_dn_o, conv_power_dn_o, irq_o;
  int          bad_count = 0, checks_done = 0; // Verdict counters.
  logic [7:0]  c, v, en_t [4] = '{8'h02, 8'h02, 8'h00, 8'h02}; // Scratch and enable masks.
  logic [7:0]  ic_t [4] = '{8'h80, 8'h40, 8'hc0, 8'hc0}; // Global masks.

  always #2 clk_i = ~clk_i;

  sacap_top dut (.clk_i, .reset_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .comparator_i, .channel_sel_o, .current_code_o, .discharge_o,
    .ref_power_dn_o, .conv_power_dn_o, .irq_o);
  sacap_ramp_model #(.HOLD_CYC(HOLD)) u_ramp (.clk_i, .discharge_i(discharge_o),
    .current_i(current_code_o), .trip_i(trip), .cmp_o(comparator_i));

  // Compare and count; an unknown matches only an unknown.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus write: address and data offered together, each released once taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'b00);
    @(posedge clk_i);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  // Bus read; data is taken at the edge where valid is seen.
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, input logic [1:0] er = 2'b00);
    @(posedge clk_i);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx, v);
    chk({24'h0, v}, {24'h0, exp});
  endtask : rdc
  // Bounded wait for the interrupt request.
  task automatic wait_irq();
    for (int i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
  endtask : wait_irq
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence: reset, registers, conversion, gating, overflow, write order.
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk({discharge_o, ref_power_dn_o, conv_power_dn_o, irq_o}, 32'he);
    rdc(`SACAP_IDX_TMR_LO, 8'h00);
    rdc(`SACAP_IDX_TMR_HI, 8'h00);
    rdc(`SACAP_IDX_CAP_LO, 8'h00);
    rdc(`SACAP_IDX_CAP_HI, 8'h00);
    rdc(`SACAP_IDX_CTRL0, `SACAP_CTRL0_RESET);
    rd(8'h3f, v, 2'b10);
    wr(8'h3f, 8'h55, 2'b10);
    wr(`SACAP_IDX_PWR, 8'h00);
    wr(`SACAP_IDX_CTRL1, 8'h50);
    chk({ref_power_dn_o, conv_power_dn_o, current_code_o}, 32'h0);
    for (int k = 0; k < 16; k++) begin
      wr(`SACAP_IDX_CTRL0, {k[3:0], 4'h2});
      repeat (2) @(posedge clk_i);
      chk({28'h0, channel_sel_o}, k);
    end
    wr(`SACAP_IDX_TMR_HI, 8'h12);
    wr(`SACAP_IDX_TMR_LO, 8'h34);
    repeat (10) @(posedge clk_i);
    rdc(`SACAP_IDX_TMR_LO, 8'h34);
    rdc(`SACAP_IDX_TMR_HI, 8'h12);
    wr(`SACAP_IDX_CAP_LO, 8'h5a);
    wr(`SACAP_IDX_CAP_HI, 8'ha5);
    s_axi_wstrb <= 4'h0;
    wr(`SACAP_IDX_CAP_LO, 8'h00);
    s_axi_wstrb <= 4'hf;
    rdc(`SACAP_IDX_CAP_LO, 8'h5a);
    rdc(`SACAP_IDX_CAP_HI, 8'ha5);
    // Conversion whose ramp trips after about a hundred cycles.
    trip <= 32'd500;
    wr(`SACAP_IDX_TMR_HI, 8'h00);
    wr(`SACAP_IDX_TMR_LO, 8'h00);
    wr(`SACAP_IDX_ENABLES, 8'h03);
    wr(`SACAP_IDX_INTCTL, 8'hc0);
    wr(`SACAP_IDX_FLAGS, 8'h00);
    repeat (HOLD) @(posedge clk_i);
    wr(`SACAP_IDX_CTRL0, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({discharge_o, current_code_o}, 32'h5);
    wait_irq();
    rdc(`SACAP_IDX_FLAGS, 8'h02);
    rd(`SACAP_IDX_CAP_LO, c);
    rdc(`SACAP_IDX_CAP_HI, 8'h00);
    chk({31'h0, c >= 8'd100 && c <= 8'd115}, 32'h1);
    rd(`SACAP_IDX_TMR_LO, v);
    chk({31'h0, v > c}, 32'h1);
    // A second trip in the same cycle must not capture again.
    trip <= '1;
    repeat (10) @(posedge clk_i);
    trip <= '0;
    repeat (20) @(posedge clk_i);
    rdc(`SACAP_IDX_CAP_LO, c);
    rdc(`SACAP_IDX_FLAGS, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(`SACAP_IDX_ENABLES, en_t[i]);
      wr(`SACAP_IDX_INTCTL, ic_t[i]);
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq_o}, {31'h0, i == 3});
    end
    wr(`SACAP_IDX_FLAGS, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    // Overflow: start just below the wrap point.
    trip <= '1;
    wr(`SACAP_IDX_CTRL0, 8'h02);
    repeat (HOLD) @(posedge clk_i);
    wr(`SACAP_IDX_TMR_HI, 8'hff);
    wr(`SACAP_IDX_TMR_LO, 8'hf0);
    wr(`SACAP_IDX_ENABLES, 8'h01);
    wr(`SACAP_IDX_CTRL0, 8'h00);
    wait_irq();
    rdc(`SACAP_IDX_FLAGS, 8'h01);
    rdc(`SACAP_IDX_TMR_HI, 8'h00);
    // Low byte written first leaves the timer stopped.
    wr(`SACAP_IDX_CTRL0, 8'h02);
    wr(`SACAP_IDX_FLAGS, 8'h00);
    repeat (HOLD) @(posedge clk_i);
    wr(`SACAP_IDX_TMR_LO, 8'h10);
    wr(`SACAP_IDX_CTRL0, 8'h00);
    repeat (20) @(posedge clk_i);
    rdc(`SACAP_IDX_TMR_LO, 8'h10);
    wr(`SACAP_IDX_TMR_HI, 8'h00);
    wr(`SACAP_IDX_TMR_LO, 8'h00);
    repeat (20) @(posedge clk_i);
    rd(`SACAP_IDX_TMR_LO, v);
    chk({31'h0, v != 8'h00}, 32'h1);
    end_of_test();
  end

  // Watchdog: the run needs under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_of_test();
  end
endmodule : test_slope_adc_timer_capture
`default_nettype wire
